// file: design/vseq_alt_ctrl.sv
// How it works
// (R1) Hold V outputs at hold position match
// (R2) Restart V outputs at restart position match
// (R3) Fourth hold gives odd-high select low bits
// (R4) Restart regs give select words' upper bits
// (R5) Holds one-three give other select low bits
// (R6) Final repetition uses group length when enabled
// (R7) Software sets final length equal normal length
// (R8) Alternation enable bit selects alternation mode
// (R9) Alternation enable sits at bit six, 0x00
// (R10) Select words give one bit per segment
// (R11) Even lines use even pair, odd odd
// (R12) Low/high bits code A B C D
// (R13) Insertion bits replace A by B/C/D
// (R14) Auto-advance increments sequence at line end
// (R15) Auto-restore returns sequence to region's one
// (R16) No hold or restart in alternation mode
// (R17) Positions compare with per-line pixel counter
`default_nettype none
module vseq_alt_ctrl
    import vseq_alt_pkg::*;
#(
    parameter int unsigned SEG_MAX = vseq_alt_pkg::SEL_W
) (
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // AXI4-Lite slave
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [vseq_alt_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [vseq_alt_pkg::DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [vseq_alt_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [vseq_alt_pkg::DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    // Line timing
    input wire logic LINE_START_I,
    input wire logic LINE_ODD_I,
    input wire logic SEG_ADV_I,
    // Repetition length request
    input wire logic [1:0] CUR_GROUP_I,
    input wire logic LAST_REP_I,
    input wire logic [vseq_alt_pkg::POS_W-1:0] NORMAL_LEN_I,
    // Special pattern insertion request
    input wire logic INSERT_REQ_I,
    // Sequence number control
    input wire logic LINE_END_I,
    input wire logic SEQ_BOUNDARY_I,
    input wire logic [vseq_alt_pkg::SEQ_W-1:0] REGION_SEQ_I,
    // Outputs toward the vertical pattern engine
    output logic [3:0] V_HOLD_O,
    output logic ALT_MODE_O,
    output logic [1:0] SEG_GROUP_O,
    output logic [vseq_alt_pkg::POS_W-1:0] REP_LEN_O,
    output logic [1:0] INSERT_GROUP_O,
    output logic INSERT_VALID_O,
    output logic [vseq_alt_pkg::SEQ_W-1:0] SEQ_NUM_O
);
    import vseq_alt_pkg::*;

    // ****************************************
    // Parameter check
    // ****************************************
    if (SEG_MAX < 1 || SEG_MAX > SEL_W) begin : g_bad_seg
        $error("SEG_MAX must be 1 to SEL_W");
    end

    localparam int unsigned SEG_IW = $clog2(SEL_W);
    localparam logic [SEG_IW-1:0] SEG_LAST = SEG_IW'(SEG_MAX - 1);
    localparam logic [POS_W-1:0] POS_MAX = '1;

    // ****************************************
    // Register storage
    // ****************************************
    logic [DATA_W-1:0] ctrl_q;
    logic [POS_W-1:0] hold_pos_q [NUM_IDX];
    logic [POS_W-1:0] restart_pos_q [NUM_IDX];
    logic [POS_W-1:0] final_len_q [NUM_IDX];
    logic [POS_W-1:0] pix_q;
    logic [SEG_IW-1:0] seg_q;
    logic [3:0] hold_q;
    logic [SEQ_W-1:0] seq_q;

    logic alt_en;
    logic [3:0] flen_en;
    logic [2:0] ins_en;
    assign alt_en = ctrl_q[BIT_ALT_EN]; // see (R8) see (R9)
    assign flen_en = ctrl_q[FLD_FLEN_LO +: 4];
    assign ins_en = ctrl_q[FLD_INS_LO +: 3];

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    logic aw_have_q, w_have_q, bvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q;
    logic wr_go;

    assign S_AXI_AWREADY_O = !aw_have_q && !bvalid_q;
    assign S_AXI_WREADY_O = !w_have_q && !bvalid_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign wr_go = aw_have_q && w_have_q;

    // Decode an address to a register bank; the index is computed separately
    function automatic logic [2:0] bank_of(input logic [ADDR_W-1:0] a);
        logic [2:0] b;
        b = 3'h0;
        if (a[1:0] != 2'h0) begin
            b = 3'h0;
        end else if (a == OFS_CTRL) begin
            b = 3'h1;
        end else if (a >= OFS_HOLD1 && a < OFS_RESTART1) begin
            b = 3'h2;
        end else if (a >= OFS_RESTART1 && a < OFS_FINAL_A) begin
            b = 3'h3;
        end else if (a >= OFS_FINAL_A && a < OFS_STATUS) begin
            b = 3'h4;
        end else if (a == OFS_STATUS) begin
            b = 3'h5;
        end
        return b;
    endfunction : bank_of

    // Merge write data under byte strobes
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
                                                input logic [3:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [2:0] wbank;
    logic [1:0] widx;
    assign wbank = bank_of(awaddr_q);
    assign widx = 2'((awaddr_q - OFS_HOLD1) >> 2) - 2'((wbank - 3'h2) * 3'h4);

    // Capture address and data in either order, answer after both
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_have_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_have_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wbank == 3'h0) ? RESP_DECERR : RESP_OKAY;
            end else if (bvalid_q && S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Register writes; status word is read only
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_q <= RST_WORD;
            for (int i = 0; i < NUM_IDX; i++) begin
                hold_pos_q[i] <= '0;
                restart_pos_q[i] <= '0;
                final_len_q[i] <= '0;
            end
        end else if (wr_go) begin
            case (wbank)
                3'h1: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
                3'h2: hold_pos_q[widx] <= POS_W'(merge(DATA_W'(hold_pos_q[widx]), wdata_q, wstrb_q));
                3'h3: restart_pos_q[widx] <= POS_W'(merge(DATA_W'(restart_pos_q[widx]), wdata_q, wstrb_q));
                3'h4: final_len_q[widx] <= POS_W'(merge(DATA_W'(final_len_q[widx]), wdata_q, wstrb_q));
                default: ;
            endcase
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic [2:0] rbank;
    logic [1:0] ridx;
    logic [DATA_W-1:0] status_w;

    assign S_AXI_ARREADY_O = !rvalid_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign rbank = bank_of(S_AXI_ARADDR_I);
    assign ridx = 2'((S_AXI_ARADDR_I - OFS_HOLD1) >> 2) - 2'((rbank - 3'h2) * 3'h4);
    assign status_w = (DATA_W'(seq_q) << ST_SEQ_LO) | (DATA_W'(hold_q) << ST_HOLD_LO)
                    | (DATA_W'(seg_q) << ST_SEG_LO);

    // Read data is registered on the same edge that takes the address
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_q <= 1'b1;
            rresp_q <= (rbank == 3'h0) ? RESP_DECERR : RESP_OKAY;
            case (rbank)
                3'h1: rdata_q <= ctrl_q;
                3'h2: rdata_q <= DATA_W'(hold_pos_q[ridx]);
                3'h3: rdata_q <= DATA_W'(restart_pos_q[ridx]);
                3'h4: rdata_q <= DATA_W'(final_len_q[ridx]);
                3'h5: rdata_q <= status_w;
                default: rdata_q <= '0;
            endcase
        end else if (rvalid_q && S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************
    // Per-line pixel counter
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pix_q <= '0;
        end else if (LINE_START_I) begin
            pix_q <= '0; // see (R17)
        end else if (pix_q != POS_MAX) begin
            pix_q <= pix_q + 1'b1;
        end
    end

    // ****************************************
    // Hold and restart of the vertical outputs
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hold_q <= '0;
        end else if (alt_en || LINE_START_I) begin
            hold_q <= '0; // see (R16)
        end else begin
            for (int k = 0; k < NUM_IDX; k++) begin
                if (pix_q == hold_pos_q[k]) begin
                    hold_q[k] <= 1'b1; // see (R1) see (R17)
                end else if (pix_q == restart_pos_q[k]) begin
                    hold_q[k] <= 1'b0; // see (R2)
                end
            end
        end
    end
    assign V_HOLD_O = hold_q;
    assign ALT_MODE_O = alt_en;

    // ****************************************
    // Alternation select words and segment walk
    // ****************************************
    logic [SEL_W-1:0] sel_lo_even, sel_hi_even, sel_lo_odd, sel_hi_odd;
    logic [SEL_W-1:0] sel_lo, sel_hi;
    assign sel_lo_even = {restart_pos_q[0][SEL_HI_W-1:0], hold_pos_q[0]}; // see (R4) see (R5)
    assign sel_hi_even = {restart_pos_q[1][SEL_HI_W-1:0], hold_pos_q[1]}; // see (R4) see (R5)
    assign sel_lo_odd = {restart_pos_q[2][SEL_HI_W-1:0], hold_pos_q[2]}; // see (R4) see (R5)
    assign sel_hi_odd = {restart_pos_q[3][SEL_HI_W-1:0], hold_pos_q[3]}; // see (R3) see (R4)
    assign sel_lo = LINE_ODD_I ? sel_lo_odd : sel_lo_even; // see (R11)
    assign sel_hi = LINE_ODD_I ? sel_hi_odd : sel_hi_even; // see (R11)

    // Segment index restarts each line and stops at the last segment
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            seg_q <= '0;
        end else if (LINE_START_I || !alt_en) begin
            seg_q <= '0;
        end else if (SEG_ADV_I && seg_q != SEG_LAST) begin
            seg_q <= seg_q + 1'b1; // see (R10)
        end
    end

    // Segment group code: low bit first, high bit second
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SEG_GROUP_O <= GRP_A;
        end else if (alt_en) begin
            SEG_GROUP_O <= {sel_lo[seg_q], sel_hi[seg_q]}; // see (R12) see (R10)
        end else begin
            SEG_GROUP_O <= GRP_A;
        end
    end

    // ****************************************
    // Final repetition length
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            REP_LEN_O <= '0;
        end else if (LAST_REP_I && flen_en[CUR_GROUP_I]) begin
            REP_LEN_O <= final_len_q[CUR_GROUP_I]; // see (R6)
        end else begin
            REP_LEN_O <= NORMAL_LEN_I;
        end
    end

    // ****************************************
    // Special pattern insertion into a group A series
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            INSERT_GROUP_O <= GRP_A;
            INSERT_VALID_O <= 1'b0;
        end else begin
            INSERT_VALID_O <= INSERT_REQ_I && (ins_en != 3'h0); // see (R13)
            if (ins_en[0]) begin
                INSERT_GROUP_O <= GRP_B; // see (R13)
            end else if (ins_en[1]) begin
                INSERT_GROUP_O <= GRP_C;
            end else if (ins_en[2]) begin
                INSERT_GROUP_O <= GRP_D;
            end else begin
                INSERT_GROUP_O <= GRP_A;
            end
        end
    end

    // ****************************************
    // Sequence number advance and restore
    // ****************************************
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            seq_q <= '0;
        end else if (LINE_END_I) begin
            if (ctrl_q[BIT_RESTORE]) begin
                seq_q <= REGION_SEQ_I; // see (R15)
            end else if (ctrl_q[BIT_ADVANCE] && !SEQ_BOUNDARY_I) begin
                seq_q <= seq_q + 1'b1; // see (R14)
            end else if (SEQ_BOUNDARY_I) begin
                seq_q <= REGION_SEQ_I;
            end
        end
    end
    assign SEQ_NUM_O = seq_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);

    a_hold_set: assert property (!alt_en && !LINE_START_I && pix_q == hold_pos_q[0] && !$changed(ctrl_q)
        |=> hold_q[0] || $past(alt_en)) // see (R1)
        else $error("hold flag not set at hold position");
    a_restart_clr: assert property (!alt_en && !LINE_START_I && pix_q == restart_pos_q[1]
        && pix_q != hold_pos_q[1] |=> !hold_q[1]) // see (R2)
        else $error("hold flag not cleared at restart position");
    a_alt_no_hold: assert property (alt_en |=> hold_q == 4'h0) // see (R16)
        else $error("hold active in alternation mode");
    a_pix_restart: assert property (LINE_START_I |=> pix_q == '0 ##1 pix_q == POS_W'(1) || LINE_START_I) // see (R17)
        else $error("pixel counter not restarted");
    a_final_len: assert property (LAST_REP_I && flen_en[CUR_GROUP_I]
        |=> REP_LEN_O == $past(final_len_q[CUR_GROUP_I])) // see (R6)
        else $error("final length not applied");
    a_normal_len: assert property (!LAST_REP_I |=> REP_LEN_O == $past(NORMAL_LEN_I)) // see (R6)
        else $error("normal length not applied");
    a_seg_code: assert property (alt_en && !LINE_ODD_I |=> SEG_GROUP_O ==
        {$past(hold_pos_q[0][0]), $past(hold_pos_q[1][0])} || $past(seg_q) != '0) // see (R12)
        else $error("wrong segment code on even line");
    a_odd_high: assert property (alt_en && LINE_ODD_I && seg_q == '0 |=> SEG_GROUP_O[0] == $past(hold_pos_q[3][0])) // see (R3)
        else $error("odd high select not from fourth hold");
    a_insert_b: assert property (INSERT_REQ_I && ins_en[0] |=> INSERT_VALID_O && INSERT_GROUP_O == GRP_B) // see (R13)
        else $error("insertion of B missing");
    a_seq_adv: assert property (LINE_END_I && ctrl_q[BIT_ADVANCE] && !ctrl_q[BIT_RESTORE] && !SEQ_BOUNDARY_I
        |=> seq_q == SEQ_W'($past(seq_q) + 1'b1)) // see (R14)
        else $error("sequence did not advance");
    a_seq_restore: assert property (LINE_END_I && ctrl_q[BIT_RESTORE] |=> seq_q == $past(REGION_SEQ_I)) // see (R15)
        else $error("sequence not restored");
    a_alt_bit: assert property ($rose(ALT_MODE_O) |-> $past(wr_go) && $past(wbank) == 3'h1) // see (R9)
        else $error("alternation mode rose without a control write");

    c_write_done: cover property (wr_go ##1 bvalid_q);
    c_alt_odd: cover property (alt_en && LINE_ODD_I && SEG_ADV_I);
    c_hold_release: cover property (hold_q[0] ##[1:20] !hold_q[0]);
    c_restore: cover property (LINE_END_I && ctrl_q[BIT_RESTORE]);
endmodule : vseq_alt_ctrl
`default_nettype wire

// file: design/vseq_alt_pkg.sv
`default_nettype none
package vseq_alt_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned POS_W = 13;
    localparam int unsigned SEL_W = 18;
    localparam int unsigned SEQ_W = 5;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SEL_HI_W = SEL_W - POS_W;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOLD1 = 8'h04;
    localparam logic [7:0] OFS_RESTART1 = 8'h14;
    localparam logic [7:0] OFS_FINAL_A = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h34;
    localparam logic [7:0] OFS_STRIDE = 8'h04;
    localparam int unsigned NUM_IDX = 4;
    // ****************************************
    // Control word fields
    // ****************************************
    localparam int unsigned BIT_ALT_EN = 6;
    localparam int unsigned FLD_FLEN_LO = 16;
    localparam int unsigned FLD_INS_LO = 20;
    localparam int unsigned BIT_ADVANCE = 23;
    localparam int unsigned BIT_RESTORE = 24;
    localparam logic [31:0] CTRL_MASK = 32'h01ff_0040;
    // ****************************************
    // Status word fields
    // ****************************************
    localparam int unsigned ST_SEQ_LO = 0;
    localparam int unsigned ST_HOLD_LO = 8;
    localparam int unsigned ST_SEG_LO = 12;
    // ****************************************
    // Reset values and responses
    // ****************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Segment codes
    localparam logic [1:0] GRP_A = 2'h0;
    localparam logic [1:0] GRP_B = 2'h1;
    localparam logic [1:0] GRP_C = 2'h2;
    localparam logic [1:0] GRP_D = 2'h3;
endpackage : vseq_alt_pkg
`default_nettype wire

// file: testbench/vseq_line_model.sv
`default_nettype none
// Line timing source standing in for the far-side sequencer
module vseq_line_model #(
    parameter int unsigned LINE_LEN = 120
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic go_i,
    input wire logic odd_i,
    output logic line_start_o,
    output logic line_end_o,
    output logic line_odd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q;
    // Line start and parity registered from go_i and odd_i; end pulse from a down counter
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            left_q <= 8'h00;
            line_start_o <= 1'b0;
            line_end_o <= 1'b0;
            line_odd_o <= 1'b0;
        end else begin
            line_start_o <= go_i;
            line_end_o <= (left_q == 8'h01);
            if (go_i) begin
                left_q <= 8'(LINE_LEN);
                line_odd_o <= odd_i;
            end else if (left_q != 8'h00) begin
                left_q <= left_q - 8'h01;
            end
        end
    end
endmodule : vseq_line_model
`default_nettype wire

// file: testbench/test_vseq_alt_ctrl.sv
`default_nettype none
module test_vseq_alt_ctrl;
    import vseq_alt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic aw_rdy, w_rdy, bv, ar_rdy, rv, alt, iv, go = 0, odd = 0, ls, le, lo;
    logic sa = 0, lr = 0, ir = 0, bnd = 0;
    logic [7:0] aw_a = 0, ar_a = 0;
    logic [31:0] w_d = 0, rd, rdat;
    logic [1:0] bresp, rresp, rs, cg = 0, sg, ig;
    logic [3:0] vh;
    logic [12:0] rl;
    logic [4:0] rseq = 0, seq;
    logic [17:0] sw [4] = '{18'h25a3c, 18'h1c3a5, 18'h30f0f, 18'h0ff00};
    int errors = 0, compares = 0, cyc = 0;
    // ****************************************
    // Clock, reset, timeout
    // ****************************************
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    // Block under test and line source
    vseq_alt_ctrl #(.SEG_MAX(18)) i_vseq_alt_ctrl (.CORE_CLK_I(clk), .NRST_I(nrst),
        .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_rdy), .S_AXI_AWADDR_I(aw_a),
        .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_rdy), .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(b_r), .S_AXI_BRESP_O(bresp),
        .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy), .S_AXI_ARADDR_I(ar_a),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(r_r), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp),
        .LINE_START_I(ls), .LINE_ODD_I(lo), .SEG_ADV_I(sa), .CUR_GROUP_I(cg), .LAST_REP_I(lr),
        .NORMAL_LEN_I(13'h0007), .INSERT_REQ_I(ir), .LINE_END_I(le), .SEQ_BOUNDARY_I(bnd),
        .REGION_SEQ_I(rseq), .V_HOLD_O(vh), .ALT_MODE_O(alt), .SEG_GROUP_O(sg), .REP_LEN_O(rl),
        .INSERT_GROUP_O(ig), .INSERT_VALID_O(iv), .SEQ_NUM_O(seq));
    vseq_line_model #(.LINE_LEN(120)) i_vseq_line_model (.clk_i(clk), .nrst_i(nrst), .go_i(go),
        .odd_i(odd), .line_start_o(ls), .line_end_o(le), .line_odd_o(lo));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge clk);
        aw_v <= 1;
        aw_a <= a;
        w_v <= 1;
        w_d <= d;
        b_r <= 1;
        while (!(ad && wd)) begin
            @(negedge clk);
            if (aw_v && aw_rdy) ad = 1;
            if (w_v && w_rdy) wd = 1;
            @(posedge clk);
            if (ad) aw_v <= 0;
            if (wd) w_v <= 0;
        end
        do @(negedge clk); while (bv !== 1'b1);
        r = bresp;
        @(posedge clk);
        b_r <= 0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ar_v <= 1;
        ar_a <= a;
        r_r <= 1;
        do @(negedge clk); while (ar_rdy !== 1'b1);
        @(posedge clk);
        ar_v <= 0;
        do @(negedge clk); while (rv !== 1'b1);
        d = rdat;
        r = rresp;
        @(posedge clk);
        r_r <= 0;
    endtask : axr
    // Starts a line; returns at the edge where the block sees the line start
    task automatic line_go(input logic o);
        @(posedge clk);
        go <= 1;
        odd <= o;
        @(posedge clk);
        go <= 0;
        @(posedge clk);
    endtask : line_go
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        axr(OFS_CTRL, rd, rs);
        chk("ctrl reset", RST_WORD, rd);
        axw(OFS_CTRL, 32'hffff_ffff, rs);
        axr(OFS_CTRL, rd, rs);
        chk("ctrl fields", CTRL_MASK, rd);
        chk("alt mode on", 1, alt);
        axw(8'h3c, 32'h1, rs);
        chk("write unmapped", RESP_DECERR, rs);
        axr(8'h38, rd, rs);
        chk("read unmapped", RESP_DECERR, rs);
        axw(OFS_CTRL, 32'h0, rs);
        chk("alt mode off", 0, alt);
    endtask : t_regs
    task automatic t_hold();
        axw(OFS_HOLD1, 32'd10, rs);
        axw(OFS_RESTART1, 32'd20, rs);
        line_go(0);
        repeat (7) @(negedge clk);
        chk("before hold", 0, vh[0]);
        repeat (10) @(negedge clk);
        chk("holding", 1, vh[0]);
        repeat (12) @(negedge clk);
        chk("restarted", 0, vh[0]);
    endtask : t_hold
    task automatic t_alt();
        axw(OFS_CTRL, 32'h40, rs);
        for (int k = 0; k < 4; k++) begin
            axw(OFS_HOLD1 + 8'(4 * k), {19'h0, sw[k][12:0]}, rs);
            axw(OFS_RESTART1 + 8'(4 * k), {27'h0, sw[k][17:13]}, rs);
        end
        axr(OFS_RESTART1, rd, rs);
        chk("restart readback", {27'h0, sw[0][17:13]}, rd);
        for (int o = 0; o < 2; o++) begin
            line_go(o[0]);
            for (int i = 0; i < 18; i++) begin
                repeat (3) @(negedge clk);
                chk("segment code", {sw[2 * o][i], sw[2 * o + 1][i]}, sg);
                chk("no hold in alt", 0, vh);
                @(posedge clk);
                sa <= 1;
                @(posedge clk);
                sa <= 0;
            end
        end
    endtask : t_alt
    task automatic t_final();
        axw(OFS_CTRL, 32'h0005_0000, rs);
        for (int g = 0; g < 4; g++) axw(OFS_FINAL_A + 8'(4 * g), 32'd100 + g, rs);
        for (int g = 0; g < 4; g++) begin
            @(posedge clk);
            cg <= g[1:0];
            lr <= 1;
            repeat (3) @(negedge clk);
            chk("final length", (g % 2 == 0) ? 100 + g : 7, rl);
        end
        axw(OFS_FINAL_A, 32'd7, rs);
        cg <= 2'h0;
        repeat (3) @(negedge clk);
        chk("final equals normal", 7, rl);
        lr <= 0;
    endtask : t_final
    task automatic t_insert();
        logic [2:0] en [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
        logic [1:0] ex [4] = '{GRP_B, GRP_C, GRP_D, GRP_B};
        for (int k = 0; k < 4; k++) begin
            axw(OFS_CTRL, {9'h0, en[k], 20'h0}, rs);
            @(posedge clk);
            ir <= 1;
            @(posedge clk);
            ir <= 0;
            @(negedge clk);
            chk("insert valid", 1, iv);
            chk("insert group", ex[k], ig);
            @(negedge clk);
            chk("insert pulse end", 0, iv);
        end
    endtask : t_insert
    task automatic t_seq();
        rseq <= 5'h03;
        axw(OFS_CTRL, 32'h0100_0000, rs);
        line_go(0);
        repeat (130) @(negedge clk);
        chk("restore", 5'h03, seq);
        axw(OFS_CTRL, 32'h0080_0000, rs);
        for (int n = 1; n < 3; n++) begin
            line_go(0);
            repeat (130) @(negedge clk);
            chk("advance", 5'h03 + n, seq);
        end
        rseq <= 5'h09;
        bnd <= 1;
        line_go(0);
        repeat (130) @(negedge clk);
        chk("boundary", 5'h09, seq);
    endtask : t_seq
    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        t_regs();
        t_hold();
        t_alt();
        t_final();
        t_insert();
        t_seq();
        final_report();
    end
endmodule : test_vseq_alt_ctrl
`default_nettype wire
